// [rtl/bcefs_params.svh]
// Constants for the boost channel enable and fault supervisor.
`ifndef BCEFS_PARAMS_SVH
`define BCEFS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define BCEFS_CLK_KHZ        40000
`define BCEFS_OT_RESTART_MS  100
`define BCEFS_HICCUP_MS      100
`define BCEFS_TIMER_W        22
`define BCEFS_SYNC_W         20

// ----------------------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------------------
`define BCEFS_ADDR_W         8
`define BCEFS_REG_CTRL       8'h00
`define BCEFS_REG_STATUS     8'h04
`define BCEFS_REG_MASK       8'h08
`define BCEFS_REG_STATE      8'h0c
`define BCEFS_CTRL_RUN_BIT   0
`define BCEFS_CTRL_CLR_BIT   1
`define BCEFS_CTRL_RST       1'b1
`define BCEFS_EV_W           8
`define BCEFS_MASK_RST       8'h00
`define BCEFS_EV_START       0
`define BCEFS_EV_WARN        1
`define BCEFS_EV_SEVERE      2
`define BCEFS_EV_TRIP        3
`define BCEFS_EV_VIN_OV      4
`define BCEFS_EV_OT          5
`define BCEFS_EV_CLIMIT      6
`define BCEFS_EV_REVERSE     7

`endif

// [rtl/bcefs_pkg.sv]
// Types shared by the boost channel enable and fault supervisor.
package bcefs_pkg;

	// ------------------------------------------------------------------------
	// Factory boost options and supervisor states
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		OPT_COLD_A  = 2'b00,
		OPT_COLD_B  = 2'b01,
		OPT_INDEP_A = 2'b10,
		OPT_INDEP_B = 2'b11
	} bcefs_opt_t;

	typedef enum logic [2:0] {
		ST_OFF     = 3'b000,
		ST_RUN     = 3'b001,
		ST_HICCUP  = 3'b010,
		ST_LATCHED = 3'b011,
		ST_SEVERE  = 3'b100,
		ST_OT_WAIT = 3'b101,
		ST_OT_HOLD = 3'b110
	} bcefs_state_t;

endpackage : bcefs_pkg

// [rtl/bcefs_sync.sv]
// Two-stage synchroniser for a vector of asynchronous inputs.
`timescale 1ns/1ps

module bcefs_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,  // Controller clock.
	input  wire logic         nrst,  // Synchronous reset, active low.
	input  wire logic         ce,    // Clock enable.
	input  wire logic [W-1:0] d,     // Asynchronous inputs.
	output logic      [W-1:0] q      // Synchronised outputs.
);

	logic [W-1:0] meta_r;

	// ------------------------------------------------------------------------
	// Two flops; only the second stage reads the first.
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			meta_r <= '0;
			q      <= '0;
		end else if (ce) begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : bcefs_sync

// [rtl/bcefs_timer.sv]
// Loadable down-counter that reports expiry one cycle after reaching one.
`timescale 1ns/1ps

module bcefs_timer #(
	parameter int W = 22
) (
	input  wire logic         mclk,     // Controller clock.
	input  wire logic         nrst,     // Synchronous reset, active low.
	input  wire logic         ce,       // Clock enable.
	input  wire logic         load,     // Start a new count.
	input  wire logic [W-1:0] load_val, // Cycles to count.
	output logic              done      // One-cycle expiry pulse.
);

	logic [W-1:0] cnt_r;

	initial begin
		if (W < 2) $error("bcefs_timer: W must be at least 2");
	end

	// ------------------------------------------------------------------------
	// Count down; a fresh load cancels any expiry in progress.
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cnt_r <= '0;
			done  <= 1'b0;
		end else if (ce) begin
			done <= !load && (cnt_r == W'(1));
			if (load) begin
				cnt_r <= load_val;
			end else if (cnt_r != '0) begin
				cnt_r <= cnt_r - W'(1);
			end
		end
	end

endmodule : bcefs_timer

// [rtl/bcefs_supervisor.sv]
// Boost channel enable, fault response and APB register file.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "bcefs_params.svh"

module bcefs_supervisor #(
	parameter int OT_CYCLES     = `BCEFS_OT_RESTART_MS * `BCEFS_CLK_KHZ,
	parameter int HICCUP_CYCLES = `BCEFS_HICCUP_MS * `BCEFS_CLK_KHZ
) (
	input  wire logic        mclk,                    // Controller clock, 40 MHz.
	input  wire logic        nrst,                    // Synchronous reset, active low.
	input  wire logic        ce,                      // Clock enable, freezes all state.
	input  wire logic        psel,                    // APB select.
	input  wire logic        penable,                 // APB enable.
	input  wire logic        pwrite,                  // APB write.
	input  wire logic [7:0]  paddr,                   // APB byte address.
	input  wire logic [31:0] pwdata,                  // APB write data.
	output logic [31:0]      prdata,                  // APB read data.
	output logic             pready,                  // APB ready.
	output logic             pslverr,                 // APB error, unmapped address.
	output logic             irq,                     // Level interrupt.
	input  wire logic [1:0]  boost_option,            // Factory boost option strap.
	input  wire logic        hiccup_not_latch,        // Factory: hiccup after hard trip.
	input  wire logic        wake_or_select,          // Factory: OR the other wake input.
	input  wire logic        boost_wake_input,        // Boost wake pin.
	input  wire logic        other_wake_input,        // Buck wake pin for OR'd wake.
	input  wire logic        battery_sense_low,       // Battery sense at or below 1.0V.
	input  wire logic        battery_sense_high,      // Battery sense above 1.03V.
	input  wire logic        battery_sense_ov,        // Input OV seen on battery sense.
	input  wire logic        supply_input_ov,         // Input OV seen on supply input.
	input  wire logic        warn_uv,                 // Fault sense warning undervoltage.
	input  wire logic        warn_ov,                 // Fault sense warning overvoltage.
	input  wire logic        severe_uv,               // Fault sense severe undervoltage.
	input  wire logic        severe_ov,               // Fault sense severe overvoltage.
	input  wire logic        cycle_current_limit,     // Current sense at 80mV.
	input  wire logic        hard_current_trip,       // Current sense at 100mV.
	input  wire logic        reverse_current,         // Current sense at -40mV.
	input  wire logic        temp_hot,                // Die above 160C.
	input  wire logic        temp_cool,               // Die below 145C.
	input  wire logic        boost_fault_flag_n_i,    // Fault flag pin level.
	output logic             boost_fault_flag_n_o,    // Fault flag drive value.
	output logic             boost_fault_flag_n_oe_n, // Fault flag enable, low drives.
	output logic             boost_run,               // Boost switching allowed.
	output logic             boost_pulse_end,         // End the present switching pulse.
	output logic             boost_reverse_limit,     // Reverse current limit active.
	output logic             buck_shutdown            // Shut the buck channel down.
);

	localparam int TW = `BCEFS_TIMER_W;

	initial begin
		if (OT_CYCLES < 2 || OT_CYCLES >= (1 << TW))
			$error("bcefs_supervisor: OT_CYCLES out of timer range");
		if (HICCUP_CYCLES < 2 || HICCUP_CYCLES >= (1 << TW))
			$error("bcefs_supervisor: HICCUP_CYCLES out of timer range");
	end

	// ------------------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------------------
	logic [`BCEFS_SYNC_W-1:0] raw;
	logic [`BCEFS_SYNC_W-1:0] s;

	assign raw = {boost_fault_flag_n_i, wake_or_select, hiccup_not_latch, boost_option,
		temp_cool, temp_hot, reverse_current, hard_current_trip, cycle_current_limit,
		severe_ov, severe_uv, warn_ov, warn_uv, supply_input_ov, battery_sense_ov,
		battery_sense_high, battery_sense_low, other_wake_input, boost_wake_input};

	bcefs_sync #(.W(`BCEFS_SYNC_W)) u_sync (
		.mclk (mclk),
		.nrst (nrst),
		.ce   (ce),
		.d    (raw),
		.q    (s)
	);

	logic wake_s, wake_alt_s, bat_low_s, bat_high_s, bat_ov_s, sup_ov_s;
	logic wuv_s, wov_s, suv_s, sov_s, climit_s, trip_s, rev_s, hot_s, cool_s;
	logic latch_sel_s, or_sel_s, flag_pin_s;
	logic [1:0] opt_s;

	assign {flag_pin_s, or_sel_s, latch_sel_s, opt_s, cool_s, hot_s, rev_s, trip_s,
		climit_s, sov_s, suv_s, wov_s, wuv_s, sup_ov_s, bat_ov_s, bat_high_s,
		bat_low_s, wake_alt_s, wake_s} = s;

	// ------------------------------------------------------------------------
	// Option capture after the synchroniser has filled
	// ------------------------------------------------------------------------
	bcefs_pkg::bcefs_opt_t opt_r;
	logic [1:0]            cap_cnt_r;
	logic                  latch_sel_r;
	logic                  or_sel_r;

	// The straps are taken once, so a glitch later cannot change the mode.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cap_cnt_r   <= 2'h0;
			opt_r       <= bcefs_pkg::OPT_COLD_A;
			latch_sel_r <= 1'b0;
			or_sel_r    <= 1'b0;
		end else if (ce && cap_cnt_r != 2'h3) begin
			cap_cnt_r <= cap_cnt_r + 2'h1;
			if (cap_cnt_r == 2'h2) begin
				opt_r       <= bcefs_pkg::bcefs_opt_t'(opt_s);
				latch_sel_r <= latch_sel_s;
				or_sel_r    <= or_sel_s;
			end
		end
	end

	logic ready;
	logic cold;
	logic uv_en;
	logic ov_en;

	assign ready = (cap_cnt_r == 2'h3);
	// Both cold-crank options share one path; only the load differs.
	assign cold  = (opt_r == bcefs_pkg::OPT_COLD_A) || (opt_r == bcefs_pkg::OPT_COLD_B);
	assign uv_en = !cold;
	assign ov_en = (opt_r == bcefs_pkg::OPT_INDEP_B);

	// ------------------------------------------------------------------------
	// Enable request
	// ------------------------------------------------------------------------
	logic cc_on_r;
	logic wake_eff;
	logic want;
	logic vin_ov;

	assign wake_eff = wake_s || (or_sel_r && wake_alt_s);

	// Cold-crank hysteresis between the 1.0V and 1.03V comparators.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cc_on_r <= 1'b0;
		end else if (ce) begin
			if (!wake_eff || bat_high_s) begin
				cc_on_r <= 1'b0;
			end else if (bat_low_s) begin
				cc_on_r <= 1'b1;
			end
		end
	end

	assign want   = ready && (cold ? cc_on_r : wake_eff);
	assign vin_ov = cold ? sup_ov_s : bat_ov_s;

	// ------------------------------------------------------------------------
	// Over-temperature flag with hysteresis
	// ------------------------------------------------------------------------
	logic ot_r;

	// A hot reading in the same cycle as the cool one keeps the flag set.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ot_r <= 1'b0;
		end else if (ce) begin
			ot_r <= hot_s || (ot_r && !cool_s);
		end
	end

	// ------------------------------------------------------------------------
	// Register file state
	// ------------------------------------------------------------------------
	logic                    sw_run_r;
	logic [`BCEFS_EV_W-1:0]  status_r;
	logic [`BCEFS_EV_W-1:0]  mask_r;
	logic [`BCEFS_EV_W-1:0]  ev;
	logic                    wr_ctrl;
	logic                    latch_clr;
	logic                    rd_status;
	logic                    access;
	logic                    mapped;

	assign access    = psel && penable && ce;
	assign mapped    = (paddr == `BCEFS_REG_CTRL) || (paddr == `BCEFS_REG_STATUS) ||
		(paddr == `BCEFS_REG_MASK) || (paddr == `BCEFS_REG_STATE);
	assign wr_ctrl   = access && pwrite && (paddr == `BCEFS_REG_CTRL);
	assign latch_clr = wr_ctrl && pwdata[`BCEFS_CTRL_CLR_BIT];
	assign rd_status = access && !pwrite && (paddr == `BCEFS_REG_STATUS);

	// ------------------------------------------------------------------------
	// Supervisor state machine
	// ------------------------------------------------------------------------
	bcefs_pkg::bcefs_state_t state_r;
	bcefs_pkg::bcefs_state_t state_nxt;
	logic                    run;
	logic                    warn_act;
	logic                    sev_act;
	logic                    tmr_load;
	logic [TW-1:0]           tmr_val;
	logic                    tmr_done;

	assign run      = (state_r == bcefs_pkg::ST_RUN);
	assign warn_act = run && ((uv_en && wuv_s) || (ov_en && wov_s));
	assign sev_act  = run && ((uv_en && suv_s) || (ov_en && sov_s));

	// Priority: temperature, input overvoltage, hard trip, severe, request.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			bcefs_pkg::ST_OFF: begin
				if (want && sw_run_r && !vin_ov) state_nxt = bcefs_pkg::ST_RUN;
			end
			bcefs_pkg::ST_RUN: begin
				if (vin_ov) begin
					state_nxt = bcefs_pkg::ST_OFF;
				end else if (trip_s) begin
					state_nxt = latch_sel_r ? bcefs_pkg::ST_HICCUP
						: bcefs_pkg::ST_LATCHED;
				end else if (sev_act) begin
					state_nxt = bcefs_pkg::ST_SEVERE;
				end else if (!want || !sw_run_r) begin
					state_nxt = bcefs_pkg::ST_OFF;
				end
			end
			bcefs_pkg::ST_HICCUP: begin
				if (tmr_done) state_nxt = bcefs_pkg::ST_OFF;
			end
			bcefs_pkg::ST_LATCHED: begin
				if (latch_clr) state_nxt = bcefs_pkg::ST_OFF;
			end
			bcefs_pkg::ST_SEVERE: begin
				if (!want) state_nxt = bcefs_pkg::ST_OFF;
			end
			bcefs_pkg::ST_OT_WAIT: begin
				if (tmr_done) state_nxt = ot_r ? bcefs_pkg::ST_OT_HOLD
					: bcefs_pkg::ST_OFF;
			end
			bcefs_pkg::ST_OT_HOLD: begin
				if (!ot_r) state_nxt = bcefs_pkg::ST_OFF;
			end
			default: state_nxt = bcefs_pkg::ST_OFF;
		endcase
		if (hot_s && state_r != bcefs_pkg::ST_OT_WAIT && state_r != bcefs_pkg::ST_OT_HOLD)
			state_nxt = bcefs_pkg::ST_OT_WAIT;
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_r <= bcefs_pkg::ST_OFF;
		end else if (ce) begin
			state_r <= state_nxt;
		end
	end

	// One timer serves both restart delays; they can never overlap.
	assign tmr_load = (state_nxt != state_r) && ((state_nxt == bcefs_pkg::ST_HICCUP) ||
		(state_nxt == bcefs_pkg::ST_OT_WAIT));
	assign tmr_val  = (state_nxt == bcefs_pkg::ST_OT_WAIT) ? TW'(OT_CYCLES)
		: TW'(HICCUP_CYCLES);

	bcefs_timer #(.W(TW)) u_timer (
		.mclk     (mclk),
		.nrst     (nrst),
		.ce       (ce),
		.load     (tmr_load),
		.load_val (tmr_val),
		.done     (tmr_done)
	);

	// ------------------------------------------------------------------------
	// Power-stage and pin outputs
	// ------------------------------------------------------------------------
	logic flag_low_r;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			boost_run           <= 1'b0;
			boost_pulse_end     <= 1'b0;
			boost_reverse_limit <= 1'b0;
			buck_shutdown       <= 1'b0;
			flag_low_r          <= 1'b0;
		end else if (ce) begin
			boost_run           <= (state_nxt == bcefs_pkg::ST_RUN);
			boost_pulse_end     <= run && climit_s;
			boost_reverse_limit <= run && rev_s;
			buck_shutdown       <= ready && vin_ov;
			flag_low_r          <= warn_act || sev_act ||
				(state_nxt == bcefs_pkg::ST_SEVERE);
		end
	end

	// Open drain: drive low only, release to let the pull-up restore high.
	assign boost_fault_flag_n_o    = 1'b0;
	assign boost_fault_flag_n_oe_n = !flag_low_r;

	// ------------------------------------------------------------------------
	// Interrupt events, sticky status and mask
	// ------------------------------------------------------------------------
	always_comb begin
		ev = '0;
		ev[`BCEFS_EV_START]   = !run && (state_nxt == bcefs_pkg::ST_RUN);
		ev[`BCEFS_EV_WARN]    = warn_act;
		ev[`BCEFS_EV_SEVERE]  = sev_act;
		ev[`BCEFS_EV_TRIP]    = run && trip_s;
		ev[`BCEFS_EV_VIN_OV]  = ready && vin_ov;
		ev[`BCEFS_EV_OT]      = hot_s;
		ev[`BCEFS_EV_CLIMIT]  = run && climit_s;
		ev[`BCEFS_EV_REVERSE] = run && rev_s;
	end

	// A read clears only the bits it returned, so events since its setup cycle stay.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			status_r <= '0;
		end else if (ce) begin
			status_r <= (status_r & ~(rd_status ? prdata[`BCEFS_EV_W-1:0] : '0)) | ev;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			mask_r   <= `BCEFS_MASK_RST;
			sw_run_r <= `BCEFS_CTRL_RST;
		end else if (access && pwrite) begin
			if (paddr == `BCEFS_REG_MASK) mask_r <= pwdata[`BCEFS_EV_W-1:0];
			if (wr_ctrl) sw_run_r <= pwdata[`BCEFS_CTRL_RUN_BIT];
		end
	end

	assign irq = |(status_r & mask_r);

	// ------------------------------------------------------------------------
	// APB slave: zero wait states, read data prepared in the setup cycle
	// ------------------------------------------------------------------------
	assign pready  = ce;
	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			prdata <= 32'h0000_0000;
		end else if (ce && psel && !penable) begin
			case (paddr)
				`BCEFS_REG_CTRL:   prdata <= {31'h0, sw_run_r};
				`BCEFS_REG_STATUS: prdata <= {24'h0, status_r};
				`BCEFS_REG_MASK:   prdata <= {24'h0, mask_r};
				`BCEFS_REG_STATE:  prdata <= {22'h0, flag_pin_s, ot_r, cc_on_r, ready,
					opt_r, 1'b0, state_r};
				default:           prdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule : bcefs_supervisor

// [bench/bcefs_plant.sv]
// Comparator model of the battery, power stage and die.
`timescale 1ns/1ps

module bcefs_plant (
	input  int   battery_mv, // Battery sense, mV.
	input  int   current_mv, // Current sense, mV.
	input  int   temp_c,     // Die temperature.
	output logic sense_low,  // At or below falling level.
	output logic sense_high, // Above rising level.
	output logic limit,      // Cycle limit level.
	output logic trip,       // Hard trip level.
	output logic reverse,    // Reverse level.
	output logic hot,        // Over-temperature.
	output logic cool        // Cooled by the hysteresis.
);
	// The gap between the two battery levels is what lets the bench probe hysteresis.
	assign sense_low  = battery_mv <= 1000;
	assign sense_high = battery_mv > 1030;
	assign limit      = current_mv >= 80;
	assign trip       = current_mv >= 100;
	assign reverse    = current_mv <= -40;
	assign hot        = temp_c >= 160;
	assign cool       = temp_c <= 145;
endmodule : bcefs_plant

// [bench/bcefs_asserts.sv]
// Port checks for the boost supervisor.
`timescale 1ns/1ps

module bcefs_asserts (
	input wire logic       mclk,                // Clock.
	input wire logic       nrst,                // Reset.
	input wire logic [1:0] boost_option,        // Strap.
	input wire logic       boost_wake_input,    // Wake.
	input wire logic       other_wake_input,    // Wake.
	input wire logic       battery_sense_low,   // In.
	input wire logic       battery_sense_high,  // In.
	input wire logic       battery_sense_ov,    // In.
	input wire logic       supply_input_ov,     // In.
	input wire logic       cycle_current_limit, // In.
	input wire logic       hard_current_trip,   // In.
	input wire logic       reverse_current,     // In.
	input wire logic       temp_hot,            // In.
	input wire logic       boost_run,           // Out.
	input wire logic       boost_pulse_end,     // Out.
	input wire logic       boost_reverse_limit, // Out.
	input wire logic       buck_shutdown        // Out.
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	logic [3:0] up_cnt_r;
	logic       up;
	// Hold checks off until the strap capture has long settled.
	always_ff @(posedge mclk) begin
		if (!nrst) up_cnt_r <= 4'h0;
		else if (up_cnt_r != 4'hf) up_cnt_r <= up_cnt_r + 4'h1;
	end
	assign up = (up_cnt_r == 4'hf);
	sequence s_cold_req;
		up && !boost_option[1] && boost_wake_input && battery_sense_low &&
			!battery_sense_high && !supply_input_ov && !hard_current_trip && !temp_hot;
	endsequence
	property p_cold_on; s_cold_req [*5] |-> boost_run; endproperty
	a_cold_on: assert property (p_cold_on) else $error("no cold start");
	property p_cold_off;
		(up && !boost_option[1] && battery_sense_high) [*5] |-> !boost_run;
	endproperty
	a_cold_off: assert property (p_cold_off) else $error("cold run stays");
	property p_ind_off;
		(up && boost_option[1] && !boost_wake_input && !other_wake_input) [*4] |-> !boost_run;
	endproperty
	a_ind_off: assert property (p_ind_off) else $error("run without wake");
	property p_ov_cold;
		(up && !boost_option[1] && supply_input_ov) [*4] |-> buck_shutdown && !boost_run;
	endproperty
	a_ov_cold: assert property (p_ov_cold) else $error("supply OV ignored");
	property p_ov_ind;
		(up && boost_option[1] && battery_sense_ov) [*4] |-> buck_shutdown && !boost_run;
	endproperty
	a_ov_ind: assert property (p_ov_ind) else $error("battery OV ignored");
	property p_trip; (up && hard_current_trip) [*4] |-> !boost_run; endproperty
	a_trip: assert property (p_trip) else $error("trip ignored");
	property p_pulse;
		(up && boost_run && cycle_current_limit) [*4] |-> boost_pulse_end;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse not ended");
	property p_rev;
		(up && boost_run && reverse_current) [*4] |-> boost_reverse_limit;
	endproperty
	a_rev: assert property (p_rev) else $error("reverse not limited");
	property p_ot; up && $rose(temp_hot) |-> ##4 (!boost_run) [*8]; endproperty
	a_ot: assert property (p_ot) else $error("early restart");
endmodule : bcefs_asserts

// [bench/bcefs_tb.sv]
// Self-checking bench for the boost supervisor.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module testbench;
	localparam int CYC = 20; // Short hiccup and over-temperature waits.
	logic        mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, hic = 1;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [1:0]  opt = 2'h0;
	logic        wake = 0, bov = 0, sov = 0, wuv = 0, wov = 0, suv = 0, sovr = 0;
	logic        orsel = 0, wk2 = 0;
	logic        pready, pslverr, irq, fo, foe_n, run, pend, rlim, bsd, pin, err;
	logic        low, high, lim, trip, rev, hot, cool;
	int          bat_mv = 1200, cur_mv = 0, temp_c = 25, err_total = 0, checks_done = 0;
	// Open-drain flag with a pull-up.
	assign pin = foe_n ? 1'b1 : fo;
	bcefs_plant u_bcefs_plant (.battery_mv(bat_mv), .current_mv(cur_mv), .temp_c(temp_c),
		.sense_low(low), .sense_high(high), .limit(lim), .trip(trip), .reverse(rev),
		.hot(hot), .cool(cool));
	bcefs_supervisor #(.OT_CYCLES(CYC), .HICCUP_CYCLES(CYC)) u_bcefs_supervisor (
		.mclk(mclk), .nrst(nrst), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .boost_option(opt), .hiccup_not_latch(hic), .wake_or_select(orsel),
		.boost_wake_input(wake), .other_wake_input(wk2), .battery_sense_low(low),
		.battery_sense_high(high), .battery_sense_ov(bov), .supply_input_ov(sov),
		.warn_uv(wuv), .warn_ov(wov), .severe_uv(suv), .severe_ov(sovr),
		.cycle_current_limit(lim), .hard_current_trip(trip), .reverse_current(rev),
		.temp_hot(hot), .temp_cool(cool), .boost_fault_flag_n_i(pin),
		.boost_fault_flag_n_o(fo), .boost_fault_flag_n_oe_n(foe_n), .boost_run(run),
		.boost_pulse_end(pend), .boost_reverse_limit(rlim), .buck_shutdown(bsd));
	// --------
	// Tasks
	// --------
	// Checks read just at an edge see settled pre-edge values.
	task cyc(input int n); repeat (n) @(posedge mclk); endtask : cyc
	task start(input logic [1:0] o);
		nrst <= 1'b0;
		opt  <= o;
		cyc(16);
		nrst <= 1'b1;
		cyc(16);
	endtask : start
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task t_cold(input logic [1:0] o);
		start(o);
		wake <= 1'b1; bat_mv <= 1015; cyc(8);
		`CHK(run, 1'b0)
		bat_mv <= 950; cyc(8);
		`CHK(run, 1'b1)
		bat_mv <= 1015; cyc(8);
		`CHK(run, 1'b1)
		bat_mv <= 950; wuv <= 1'b1; sovr <= 1'b1; bov <= 1'b1; cyc(8);
		`CHK({run, foe_n, bsd}, 3'b110)
		wuv <= 1'b0; sovr <= 1'b0; bov <= 1'b0; sov <= 1'b1; cyc(8);
		`CHK({run, bsd}, 2'b01)
		sov <= 1'b0; cyc(8);
		`CHK({run, bsd}, 2'b10)
		bat_mv <= 1040; cyc(8);
		`CHK(run, 1'b0)
		wake <= 1'b0; bat_mv <= 1200;
	endtask : t_cold
	task t_indep(input logic [1:0] o);
		start(o);
		bat_mv <= 950; cyc(8);
		`CHK(run, 1'b0)
		wake <= 1'b1; bat_mv <= 1200; sov <= 1'b1; wov <= 1'b1; cyc(8);
		`CHK({run, bsd, foe_n}, {2'b10, o != 2'h3})
		sov <= 1'b0; wov <= 1'b0; wuv <= 1'b1; cyc(8);
		`CHK({run, foe_n}, 2'b10)
		wuv <= 1'b0; cyc(8);
		`CHK(foe_n, 1'b1)
		suv <= 1'b1; cyc(8);
		`CHK({run, foe_n}, 2'b00)
		suv <= 1'b0; bov <= 1'b1; cyc(8);
		`CHK(bsd, 1'b1)
		bov <= 1'b0; wake <= 1'b0; cyc(8);
	endtask : t_indep
	task t_trip;
		start(2'h3);
		wake <= 1'b1; cur_mv <= 85; cyc(8);
		`CHK({run, pend}, 2'b11)
		cur_mv <= -45; cyc(8);
		`CHK({run, rlim}, 2'b11)
		cur_mv <= 105; cyc(6);
		`CHK(run, 1'b0)
		cur_mv <= 0; cyc(CYC + 14);
		`CHK(run, 1'b1)
		temp_c <= 170; cyc(6);
		`CHK(run, 1'b0)
		temp_c <= 150; cyc(CYC + 14);
		`CHK(run, 1'b0)
		temp_c <= 140; cyc(16);
		`CHK(run, 1'b1)
	endtask : t_trip
	// Status holds the trip scenario's events: start, trip, over-temperature, limit, reverse.
	task t_regs;
		apb(1'b0, 8'h00, 32'h0);
		`CHK(rd, 32'h1)
		apb(1'b0, 8'h08, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b1, 8'h08, 32'hff); cyc(2);
		`CHK(irq, 1'b1)
		apb(1'b1, 8'h08, 32'h0); cyc(2);
		`CHK(irq, 1'b0)
		apb(1'b0, 8'h04, 32'h0);
		`CHK(rd, 32'h0000_00e9)
		apb(1'b1, 8'h08, 32'hff); cyc(2);
		`CHK(irq, 1'b0)
		apb(1'b0, 8'h0c, 32'h0);
		`CHK(rd, 32'h0000_0271)
		apb(1'b0, 8'h10, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
	endtask : t_regs
	// Latch-off after a hard trip, released by the control write; boost runs on the other wake.
	task t_latch;
		hic <= 1'b0; orsel <= 1'b1; wake <= 1'b0;
		start(2'h3);
		wk2 <= 1'b1; cyc(8);
		`CHK(run, 1'b1)
		cur_mv <= 105; cyc(8);
		cur_mv <= 0; cyc(CYC + 14);
		`CHK(run, 1'b0)
		apb(1'b1, 8'h00, 32'h3); cyc(8);
		`CHK(run, 1'b1)
	endtask : t_latch
	task wrap_up;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	// --------
	// Run
	// --------
	initial forever #12.5 mclk = ~mclk;
	initial begin
		t_cold(2'h0);
		t_cold(2'h1);
		t_indep(2'h2);
		t_indep(2'h3);
		t_trip;
		t_regs;
		t_latch;
		wrap_up;
	end
	// The scenarios need under two thousand cycles; the limit leaves ample slack.
	initial begin
		#150000;
		err_total++;
		wrap_up;
	end
endmodule : testbench

bind bcefs_supervisor bcefs_asserts u_bcefs_asserts (.*);
